// ===== rtl/event_status.sv
/*
 Sticky event register with write-one-to-clear, a mask of the same layout
 and one level interrupt.
 Assumes events are one-cycle pulses on the core clock.
*/
`timescale 1ns/1ps
module event_status (
   input  wire logic                          core_clk_i, // Core clock.
   input  wire logic                          rst_n_i,    // Sync reset, low.
   input  wire logic [handshake_pkg::EV_N-1:0] event_i,   // Event pulses.
   input  wire logic                          clr_we_i,   // Clear strobe.
   input  wire logic                          mask_we_i,  // Mask write strobe.
   input  wire logic [handshake_pkg::EV_N-1:0] wdata_i,   // Write data.
   output logic      [handshake_pkg::EV_N-1:0] status_o,  // Sticky events.
   output logic      [handshake_pkg::EV_N-1:0] mask_o,    // Enable mask.
   output logic                               irq_o       // Interrupt level.
);
   logic [handshake_pkg::EV_N-1:0] status_r;
   logic [handshake_pkg::EV_N-1:0] mask_r;

   // A new event beats a clear in the same cycle, so nothing is lost.
   for (genvar b = 0; b < handshake_pkg::EV_N; b++)
   begin : g_ev
      always_ff @(posedge core_clk_i)
      begin
         if (!rst_n_i)
         begin
            status_r[b] <= 1'b0;
         end
         else if (event_i[b])
         begin
            status_r[b] <= 1'b1;
         end
         else if (clr_we_i && wdata_i[b])
         begin
            status_r[b] <= 1'b0;
         end
      end
   end

   // Mask register.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         mask_r <= handshake_pkg::MASK_RESET;
      end
      else if (mask_we_i)
      begin
         mask_r <= wdata_i;
      end
   end

   assign status_o = status_r;
   assign mask_o   = mask_r;
   assign irq_o    = |(status_r & mask_r);
endmodule : event_status

// ===== rtl/handshake_pkg.sv
/*
 Constants for the serial-port handshake selector: register map, field
 positions, reset values and bus response codes.
 Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz core clock.
*/
// Function
// - No reader: synthesize reader ready for ready, DTR.
// - Reader present: use the real reader ready.
// - Synthesize DSR when selected, else use device's.
// - Current loop always synthesizes data set ready.
// - External CTS answers our request to send.
// - External CTS off: clear to send generated internally.
// - Terminal port active: CTS selection has no effect.
// - Current loop active: clear to send synthesized.
// - Parity drop on: parity error drops ready, DTR.
// - Dropped ready never stops sending or receiving.
// - Parity drop off: parity errors leave ready alone.
package handshake_pkg;
   // Bus geometry and answers.
   localparam int          ADDR_W      = 5;
   localparam int          DATA_W      = 32;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   // Register byte offsets.
   localparam logic [4:0]  OFF_CTRL    = 5'h00;
   localparam logic [4:0]  OFF_STATUS  = 5'h04;
   localparam logic [4:0]  OFF_EVENT   = 5'h08;
   localparam logic [4:0]  OFF_MASK    = 5'h0c;
   // Control field: write one to lift a parity-induced ready drop.
   localparam int          CTRL_RELEASE = 0;
   // Status fields.
   localparam int          ST_READER   = 0;
   localparam int          ST_DTR      = 1;
   localparam int          ST_DSR      = 2;
   localparam int          ST_CTS      = 3;
   localparam int          ST_DROP     = 4;
   localparam int          ST_CFG_LSB  = 8;
   // Option vector positions.
   localparam int          CFG_N       = 6;
   localparam int          CFG_READER  = 0;
   localparam int          CFG_DSR_SYN = 1;
   localparam int          CFG_CTS_MODEM = 2;
   localparam int          CFG_PAR     = 3;
   localparam int          CFG_TERM    = 4;
   localparam int          CFG_LOOP    = 5;
   // Event bits, shared by the event and mask registers.
   localparam int          EV_N        = 3;
   localparam int          EV_PARITY   = 0;
   localparam int          EV_DROP     = 1;
   localparam int          EV_RDY_FALL = 2;
   localparam logic [2:0]  MASK_RESET  = 3'h0;
   // Synchronised pin positions.
   localparam int          PIN_N       = 3;
   localparam int          PIN_READER  = 0;
   localparam int          PIN_DSR     = 1;
   localparam int          PIN_CTS     = 2;
endpackage : handshake_pkg

// ===== rtl/pin_sync.sv
/*
 Three-stage synchroniser with agreement filter for slow external levels.
 Assumes inputs change far slower than the core clock; no reset is used so
 that levels are already valid while the core is held in reset.
*/
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk_i, // Core clock.
   input  wire logic [WIDTH-1:0] d_i,        // Asynchronous levels.
   output logic      [WIDTH-1:0] q_o         // Filtered levels.
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] q_r;

   // Stage one feeds only stage two; the output moves once two and three agree.
   for (genvar b = 0; b < WIDTH; b++)
   begin : g_bit
      always_ff @(posedge core_clk_i)
      begin
         s1_r[b] <= d_i[b];
         s2_r[b] <= s1_r[b];
         s3_r[b] <= s2_r[b];
         if (s2_r[b] == s3_r[b])
         begin
            q_r[b] <= s3_r[b];
         end
      end
   end

   assign q_o = q_r;
endmodule : pin_sync

// ===== rtl/serial_ready_handshake_select.sv
/*
 Handshake selector for the serial port of a paper-tape interface: picks
 the source of reader ready, data set ready and clear to send, and lets a
 received parity error drop the ready indicator and data terminal ready.
 Assumes static option switches, pins asynchronous to the core clock, and a
 transmitter and receiver on the core clock supplying request and parity.
*/
`timescale 1ns/1ps
module serial_ready_handshake_select (
   input  wire logic        core_clk_i,               // 50 MHz core clock.
   input  wire logic        rst_n_i,                  // Sync reset, low.
   input  wire logic        reader_present_sel_i,     // Tape reader fitted.
   input  wire logic        dsr_synth_sel_i,          // Synthesize DSR.
   input  wire logic        cts_external_sel_i,       // Use modem CTS.
   input  wire logic        parity_drops_ready_sel_i, // Parity drops ready.
   input  wire logic        terminal_port_sel_i,      // Terminal port active.
   input  wire logic        current_loop_sel_i,       // Current loop active.
   input  wire logic        reader_ready_i,           // Reader ready pin.
   input  wire logic        dsr_ext_i,                // Device DSR pin.
   input  wire logic        cts_modem_i,              // Modem CTS pin.
   input  wire logic        tx_request_i,             // Transmitter wants line.
   input  wire logic        parity_err_i,             // Receive parity pulse.
   output logic             ready_led_o,              // Ready indicator.
   output logic             dtr_o,                    // Data terminal ready.
   output logic             dsr_o,                    // Effective DSR.
   output logic             rts_o,                    // Request to send.
   output logic             cts_o,                    // Effective CTS.
   output logic             tx_permit_o,              // Transmit allowed.
   output logic             irq_o,                    // Interrupt level.
   input  wire logic [4:0]  s_axi_awaddr_i,           // Write address.
   input  wire logic        s_axi_awvalid_i,          // Write address valid.
   output logic             s_axi_awready_o,          // Write address ready.
   input  wire logic [31:0] s_axi_wdata_i,            // Write data.
   input  wire logic [3:0]  s_axi_wstrb_i,            // Byte enables.
   input  wire logic        s_axi_wvalid_i,           // Write data valid.
   output logic             s_axi_wready_o,           // Write data ready.
   output logic [1:0]       s_axi_bresp_o,            // Write response.
   output logic             s_axi_bvalid_o,           // Write response valid.
   input  wire logic        s_axi_bready_i,           // Write response ready.
   input  wire logic [4:0]  s_axi_araddr_i,           // Read address.
   input  wire logic        s_axi_arvalid_i,          // Read address valid.
   output logic             s_axi_arready_o,          // Read address ready.
   output logic [31:0]      s_axi_rdata_o,            // Read data.
   output logic [1:0]       s_axi_rresp_o,            // Read response.
   output logic             s_axi_rvalid_o,           // Read data valid.
   input  wire logic        s_axi_rready_i            // Read data ready.
);
   logic [handshake_pkg::CFG_N-1:0] cfg_s;
   logic [handshake_pkg::CFG_N-1:0] cfg_r;
   logic [handshake_pkg::PIN_N-1:0] pin_s;
   logic [handshake_pkg::EV_N-1:0]  ev_c;
   logic [handshake_pkg::EV_N-1:0]  ev_status;
   logic [handshake_pkg::EV_N-1:0]  ev_mask;
   logic        reader_ok_c;
   logic        dsr_synth_c;
   logic        dsr_c;
   logic        cts_modem_mode_c;
   logic        cts_c;
   logic        release_c;
   logic        drop_r;
   logic        ready_r;
   logic        dsr_r;
   logic        rts_r;
   logic        cts_r;
   logic        permit_r;
   logic        aw_held_r;
   logic        w_held_r;
   logic [4:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        wr_go_c;
   logic        wr_lane0_c;
   logic        wr_map_c;
   logic [31:0] rd_mux_c;
   logic        rd_map_c;

   // Option switches and pins are asynchronous, so both pass the filter.
   pin_sync #(.WIDTH(handshake_pkg::CFG_N)) u_cfg_sync (
      .core_clk_i (core_clk_i),
      .d_i        ({current_loop_sel_i, terminal_port_sel_i,
                    parity_drops_ready_sel_i, cts_external_sel_i,
                    dsr_synth_sel_i, reader_present_sel_i}),
      .q_o        (cfg_s)
   );

   pin_sync #(.WIDTH(handshake_pkg::PIN_N)) u_pin_sync (
      .core_clk_i (core_clk_i),
      .d_i        ({cts_modem_i, dsr_ext_i, reader_ready_i}),
      .q_o        (pin_s)
   );

   // Options are tracked only while reset is held, then frozen; a switch
   // moved during operation takes effect at the next reset.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         cfg_r <= cfg_s;
      end
   end

   // Source selection for reader ready, data set ready and clear to send.
   always_comb
   begin
      reader_ok_c = cfg_r[handshake_pkg::CFG_READER]
                    ? pin_s[handshake_pkg::PIN_READER] : 1'b1;
      dsr_synth_c = cfg_r[handshake_pkg::CFG_DSR_SYN]
                    | cfg_r[handshake_pkg::CFG_LOOP];
      dsr_c       = dsr_synth_c | pin_s[handshake_pkg::PIN_DSR];
      cts_modem_mode_c = cfg_r[handshake_pkg::CFG_CTS_MODEM]
                         & ~cfg_r[handshake_pkg::CFG_TERM]
                         & ~cfg_r[handshake_pkg::CFG_LOOP];
      cts_c = cts_modem_mode_c
              ? (rts_r & pin_s[handshake_pkg::PIN_CTS])
              : rts_r;
   end

   // Parity drop latch; an error in the release cycle keeps the drop.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         drop_r <= 1'b0;
      end
      else if (parity_err_i && cfg_r[handshake_pkg::CFG_PAR])
      begin
         drop_r <= 1'b1;
      end
      else if (release_c)
      begin
         drop_r <= 1'b0;
      end
   end

   // Ready drives both the indicator and data terminal ready.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         ready_r <= 1'b0;
      end
      else
      begin
         ready_r <= reader_ok_c & ~drop_r;
      end
   end

   // Line handshake outputs; the drop is left out so data keeps flowing.
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         dsr_r    <= 1'b0;
         rts_r    <= 1'b0;
         cts_r    <= 1'b0;
         permit_r <= 1'b0;
      end
      else
      begin
         dsr_r    <= dsr_c;
         rts_r    <= tx_request_i;
         cts_r    <= cts_c;
         permit_r <= cts_c & dsr_c;
      end
   end

   assign ready_led_o = ready_r;
   assign dtr_o       = ready_r;
   assign dsr_o       = dsr_r;
   assign rts_o       = rts_r;
   assign cts_o       = cts_r;
   assign tx_permit_o = permit_r;

   // Events: any parity error, a ready drop, and loss of ready.
   always_comb
   begin
      ev_c = '0;
      ev_c[handshake_pkg::EV_PARITY]   = parity_err_i;
      ev_c[handshake_pkg::EV_DROP]     = parity_err_i & cfg_r[handshake_pkg::CFG_PAR]
                                         & ~drop_r;
      ev_c[handshake_pkg::EV_RDY_FALL] = ready_r & ~(reader_ok_c & ~drop_r);
   end

   event_status u_events (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .event_i    (ev_c),
      .clr_we_i   (wr_go_c && wr_lane0_c && awaddr_r == handshake_pkg::OFF_EVENT),
      .mask_we_i  (wr_go_c && wr_lane0_c && awaddr_r == handshake_pkg::OFF_MASK),
      .wdata_i    (wdata_r[handshake_pkg::EV_N-1:0]),
      .status_o   (ev_status),
      .mask_o     (ev_mask),
      .irq_o      (irq_o)
   );

   // Write channel: address and data are taken in either order and held.
   assign s_axi_awready_o = ~aw_held_r & ~bvalid_r;
   assign s_axi_wready_o  = ~w_held_r & ~bvalid_r;
   assign wr_go_c    = aw_held_r & w_held_r & ~bvalid_r;
   assign wr_lane0_c = wstrb_r[0];
   assign wr_map_c   = awaddr_r[1:0] == 2'h0 && awaddr_r[4] == 1'b0;
   assign release_c  = wr_go_c && wr_lane0_c && awaddr_r == handshake_pkg::OFF_CTRL
                       && wdata_r[handshake_pkg::CTRL_RELEASE];

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 5'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= handshake_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata_i;
            wstrb_r  <= s_axi_wstrb_i;
         end
         if (wr_go_c)
         begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_map_c ? handshake_pkg::RESP_OKAY : handshake_pkg::RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready_i)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o  = bresp_r;

   // Read data mux; the control register reads zero since release is a pulse.
   always_comb
   begin
      rd_mux_c = 32'h0000_0000;
      rd_map_c = 1'b1;
      unique case (s_axi_araddr_i)
         handshake_pkg::OFF_CTRL:
         begin
            rd_mux_c = 32'h0000_0000;
         end
         handshake_pkg::OFF_STATUS:
         begin
            rd_mux_c[handshake_pkg::ST_READER] = reader_ok_c;
            rd_mux_c[handshake_pkg::ST_DTR]    = ready_r;
            rd_mux_c[handshake_pkg::ST_DSR]    = dsr_r;
            rd_mux_c[handshake_pkg::ST_CTS]    = cts_r;
            rd_mux_c[handshake_pkg::ST_DROP]   = drop_r;
            rd_mux_c[handshake_pkg::ST_CFG_LSB +: handshake_pkg::CFG_N] = cfg_r;
         end
         handshake_pkg::OFF_EVENT:
         begin
            rd_mux_c[handshake_pkg::EV_N-1:0] = ev_status;
         end
         handshake_pkg::OFF_MASK:
         begin
            rd_mux_c[handshake_pkg::EV_N-1:0] = ev_mask;
         end
         default:
         begin
            rd_map_c = 1'b0;
         end
      endcase
   end

   // Read channel: one outstanding read, answered on the same edge as the take.
   assign s_axi_arready_o = ~rvalid_r;

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= handshake_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux_c;
         rresp_r  <= rd_map_c ? handshake_pkg::RESP_OKAY : handshake_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready_i)
      begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o  = rdata_r;
   assign s_axi_rresp_o  = rresp_r;

   // Checks on the selection behaviour.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_perr;
      cfg_r[handshake_pkg::CFG_PAR] && parity_err_i;
   endsequence
   sequence s_no_release;
      !release_c;
   endsequence

   property p_synth_reader;
      (!cfg_r[handshake_pkg::CFG_READER] && !drop_r) |=> ready_r && dtr_o;
   endproperty
   a_synth_reader: assert property (p_synth_reader) else $error("ready not synthesized");

   property p_real_reader;
      (cfg_r[handshake_pkg::CFG_READER] && !pin_s[handshake_pkg::PIN_READER]) |=> !dtr_o;
   endproperty
   a_real_reader: assert property (p_real_reader) else $error("ready without reader");

   property p_dsr_ext;
      !dsr_synth_c |=> dsr_o == $past(pin_s[handshake_pkg::PIN_DSR]);
   endproperty
   a_dsr_ext: assert property (p_dsr_ext) else $error("DSR not from device");

   property p_dsr_loop;
      cfg_r[handshake_pkg::CFG_LOOP] || cfg_r[handshake_pkg::CFG_DSR_SYN] |=> dsr_o;
   endproperty
   a_dsr_loop: assert property (p_dsr_loop) else $error("DSR not synthesized");

   property p_cts_modem;
      (cts_modem_mode_c && (!pin_s[handshake_pkg::PIN_CTS] || !rts_o)) |=> !cts_o;
   endproperty
   a_cts_modem: assert property (p_cts_modem) else $error("CTS without modem answer");

   property p_cts_int;
      (rts_o && (!cfg_r[handshake_pkg::CFG_CTS_MODEM] || cfg_r[handshake_pkg::CFG_TERM]
                 || cfg_r[handshake_pkg::CFG_LOOP])) |=> cts_o;
   endproperty
   a_cts_int: assert property (p_cts_int) else $error("CTS not synthesized");

   property p_parity_drop;
      s_perr ##1 s_no_release |=> !dtr_o && !ready_led_o;
   endproperty
   a_parity_drop: assert property (p_parity_drop) else $error("parity did not drop ready");

   property p_keep_sending;
      (drop_r && rts_o && dsr_synth_c && !cts_modem_mode_c) |=> tx_permit_o;
   endproperty
   a_keep_sending: assert property (p_keep_sending) else $error("drop stopped transmit");

   property p_parity_off;
      !cfg_r[handshake_pkg::CFG_PAR] |-> !drop_r;
   endproperty
   a_parity_off: assert property (p_parity_off) else $error("parity drop while disabled");

   property p_dtr_cause;
      dtr_o |-> $past(reader_ok_c) && !$past(drop_r);
   endproperty
   a_dtr_cause: assert property (p_dtr_cause) else $error("DTR without cause");

   property p_cfg_frozen;
      $past(rst_n_i) |-> $stable(cfg_r);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen) else $error("options changed in run");
endmodule : serial_ready_handshake_select

// ===== test/serial_dev_model.sv
/*
 Model of the serial device on the modem port: a ready line and a clear
 to send that answers request to send, promptly or late.
 Assumes the core clock paces the model.
*/
`timescale 1ns/1ps
module serial_dev_model (
   input  wire logic core_clk_i, // Core clock.
   input  wire logic rts_i,      // Request to send.
   input  wire logic has_rdy_i,  // Device owns a ready line.
   input  wire logic slow_i,     // Answer late.
   output logic      dsr_o,      // Device ready.
   output logic      cts_o       // Clear to send.
);
   int cnt;
   // A device without a ready line leaves it low, so synthesis must be on.
   assign dsr_o = has_rdy_i;
   // Clear to send rises only after request to send; late mode tests waiting.
   always_ff @(posedge core_clk_i)
   begin
      cnt   <= rts_i ? cnt + 1 : 0;
      cts_o <= rts_i && (cnt >= (slow_i ? 6 : 1));
   end
endmodule : serial_dev_model

// ===== test/serial_ready_handshake_select_tb.sv
/*
 Self-checking bench for the handshake selector: option sets, pin levels,
 parity drops, events and the register bus.
 Assumes the serial device model on the modem port pins.
*/
`timescale 1ns/1ps
module serial_ready_handshake_select_tb;
   logic        clk = 1'h0, rst_n = 1'h0, rdr = 1'h0, txr = 1'h0, par = 1'h0;
   logic        has_rdy = 1'h0, slow = 1'h0;
   logic [5:0]  opt = 6'h0, o;
   logic        led, dtr, dsr, dsr_x, rts, cts, cts_m, permit, irq;
   logic [4:0]  awaddr = 5'h0, araddr = 5'h0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        awv = 1'h0, wv = 1'h0, bready = 1'h0, arv = 1'h0, rready = 1'h0;
   logic        awr, wrr, bv, arr, rv;
   logic [1:0]  bresp, rresp, resp;
   int          checks = 0, n_mismatch = 0;

   // Free-running 50 MHz clock.
   initial forever #10 clk = ~clk;

   serial_ready_handshake_select dut (.core_clk_i(clk), .rst_n_i(rst_n),
      .reader_present_sel_i(opt[0]), .dsr_synth_sel_i(opt[1]),
      .cts_external_sel_i(opt[2]), .parity_drops_ready_sel_i(opt[3]),
      .terminal_port_sel_i(opt[4]), .current_loop_sel_i(opt[5]),
      .reader_ready_i(rdr), .dsr_ext_i(dsr_x), .cts_modem_i(cts_m),
      .tx_request_i(txr), .parity_err_i(par), .ready_led_o(led), .dtr_o(dtr),
      .dsr_o(dsr), .rts_o(rts), .cts_o(cts), .tx_permit_o(permit), .irq_o(irq),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rready));

   serial_dev_model dev (.core_clk_i(clk), .rts_i(rts), .has_rdy_i(has_rdy),
      .slow_i(slow), .dsr_o(dsr_x), .cts_o(cts_m));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Handshakes are sampled on the falling edge, where all is settled.
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
      bit ad, wd, bd = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata  <= v;
      awv    <= 1'h1;
      wv     <= 1'h1;
      bready <= 1'h1;
      while (!bd)
      begin
         @(negedge clk);
         ad   = awv && awr;
         wd   = wv && wrr;
         bd   = bv;
         resp = bresp;
         @(posedge clk);
         if (ad) awv <= 1'h0;
         if (wd) wv <= 1'h0;
      end
      bready <= 1'h0;
   endtask : axi_wr

   task automatic axi_rd(input logic [4:0] a);
      bit ah, rd = 1'b0;
      @(posedge clk);
      araddr <= a;
      arv    <= 1'h1;
      rready <= 1'h1;
      while (!rd)
      begin
         @(negedge clk);
         ah   = arv && arr;
         rd   = rv;
         d    = rdata;
         resp = rresp;
         @(posedge clk);
         if (ah) arv <= 1'h0;
      end
      rready <= 1'h0;
   endtask : axi_rd

   // Options are only taken while reset is held, so each set needs a reset.
   task automatic cfg(input logic [5:0] v);
      @(posedge clk);
      opt   <= v;
      rst_n <= 1'h0;
      txr   <= 1'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      settle(8);
   endtask : cfg

   task automatic pulse_par;
      @(posedge clk);
      par <= 1'h1;
      @(posedge clk);
      par <= 1'h0;
      settle(1);
   endtask : pulse_par

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   // A hang counts as a mismatch and ends the run in the usual place.
   initial
   begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      finish_test();
   end

   initial
   begin
      cfg(6'h0a);
      chk("led", 32'h1, led);
      chk("dtr", 32'h1, dtr);
      chk("dsr", 32'h1, dsr);
      axi_rd(handshake_pkg::OFF_STATUS);
      chk("cfg", 32'h0a, d[13:8]);
      @(posedge clk);
      txr <= 1'h1;
      settle(3);
      chk("cts", 32'h1, cts);
      chk("rts", 32'h1, rts);
      pulse_par();
      chk("dtr", 32'h0, dtr);
      chk("led", 32'h0, led);
      chk("permit", 32'h1, permit);
      axi_rd(handshake_pkg::OFF_EVENT);
      chk("event", 32'h7, d);
      chk("irq", 32'h0, irq);
      axi_wr(handshake_pkg::OFF_MASK, 32'h1);
      settle(1);
      chk("irq", 32'h1, irq);
      axi_wr(handshake_pkg::OFF_CTRL, 32'h1);
      settle(2);
      chk("dtr", 32'h1, dtr);
      axi_wr(handshake_pkg::OFF_EVENT, 32'h7);
      axi_rd(handshake_pkg::OFF_EVENT);
      chk("event", 32'h0, d);
      chk("irq", 32'h0, irq);
      axi_rd(5'h10);
      chk("rresp", handshake_pkg::RESP_SLVERR, resp);
      chk("rdata", 32'h0, d);
      axi_wr(5'h14, 32'h1);
      chk("bresp", handshake_pkg::RESP_SLVERR, resp);
      @(posedge clk);
      opt <= 6'h0b;
      settle(8);
      chk("led", 32'h1, led);
      // Reader fitted, device ready line, modem clear to send, answered late.
      slow <= 1'h1;
      cfg(6'h05);
      chk("led", 32'h0, led);
      chk("dsr", 32'h0, dsr);
      @(posedge clk);
      rdr     <= 1'h1;
      has_rdy <= 1'h1;
      txr     <= 1'h1;
      settle(3);
      chk("cts", 32'h0, cts);
      settle(15);
      chk("cts", 32'h1, cts);
      chk("led", 32'h1, led);
      chk("dsr", 32'h1, dsr);
      pulse_par();
      settle(1);
      chk("dtr", 32'h1, dtr);
      // Terminal port, then current loop, both with modem CTS selected.
      has_rdy <= 1'h0;
      for (int i = 0; i < 2; i++)
      begin
         o = i ? 6'h24 : 6'h14;
         cfg(o);
         chk("dsr", o[5], dsr);
         @(posedge clk);
         txr <= 1'h1;
         settle(3);
         chk("cts", 32'h1, cts);
      end
      finish_test();
   end
endmodule : serial_ready_handshake_select_tb
